/* File: dv/nbt_die_model.sv */
// behavioural nand die on the far side of nbt_host: busy pin, status byte, read data
// assumes one documented microsecond lasts one ns here, so every busy time stays short
`timescale 1ns/1ns
module nbt_die_model
  import nbt_pkg::*;
(
  input  wire nbt_pins_type pins,
  output logic [7:0]        dataIn,
  output logic              readyBusy_n
);
  int         lateCmds   = 0;
  time        lastRise   = 0;
  logic       resetSeen  = 1'b0;
  logic       switching  = 1'b0;
  logic       statusMode = 1'b0;
  logic [7:0] cmd;
  int         busyNs;

  // ready is valid and high before the first reset
  initial
  begin
    dataIn = 8'h00;
    readyBusy_n = 1'b1;
  end

  task automatic hold(input int d);
    #50 readyBusy_n = 1'b0;
    #(d) readyBusy_n = 1'b1;
    switching = 1'b0;
  endtask

  // host slips are counted, not punished, so the bench can report them
  always @(negedge pins.writeStrobe_n)
    if (!pins.chipEnable_n && pins.cmdLatch && $time - lastRise < 100)
      lateCmds++;

  always @(posedge pins.writeStrobe_n)
    if (!pins.chipEnable_n && pins.cmdLatch)
    begin
      cmd = pins.dataOut;
      lastRise = $time;
      if (!resetSeen && cmd != CMD_RESET)
        lateCmds++;
      if (switching && (cmd == CMD_STATUS || cmd == CMD_STATUSX))
        lateCmds++;
      statusMode = (cmd == CMD_STATUS);
      case (cmd)
        CMD_RESET:    busyNs = resetSeen ? 5 : 1000;
        8'h30:        busyNs = 50;
        8'h10:        busyNs = 2200;
        8'h15:        busyNs = 2200;
        8'hd0:        busyNs = 10000;
        8'h31, 8'h3f: busyNs = 50;
        default:      busyNs = 1;
      endcase
      switching = (cmd == CMD_SETFEAT) || (cmd == CMD_RESET && resetSeen);
      if (cmd == CMD_RESET)
        resetSeen = 1'b1;
      if (!(cmd inside {CMD_STATUS, CMD_STATUSX, CMD_COLREAD, CMD_COLWRITE}))
        fork
          hold(busyNs);
        join_none
    end

  // data held until chip enable rises, which covers short read cycles
  always @(negedge pins.readStrobe_n)
    if (!pins.chipEnable_n)
      dataIn <= #16 statusMode ? {1'b0, readyBusy_n, readyBusy_n, 5'h00}
                               : 8'h3c;

  // no pull on the data lines: 30 ns after each chip enable rise the bus inverts, so two releases bring back the old byte
  always @(posedge pins.chipEnable_n)
    dataIn <= #30 ~dataIn;
endmodule

/* File: dv/nbt_host_tb.sv */
// self-checking bench: apb software cycles drive nbt_host against the die model
// assumes a 25 MHz mclk and a short busy timeout so the run stays brief
`timescale 1ns/1ns
module nbt_host_tb
  import nbt_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic [7:0]   dataIn;
  logic         readyBusy_n;
  nbt_pins_type pins;
  int           error_cnt = 0;
  int           n_checks = 0;
  int           lastCyc;
  logic [31:0]  r;
  logic         e;

  always #20 mclk = ~mclk;

  nbt_host #(.TIMEOUT_CYC(400)) nbt_host_i (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .dataIn(dataIn),
    .readyBusy_n(readyBusy_n), .irq(irq));
  nbt_die_model nbt_die_model_i (.pins(pins), .dataIn(dataIn), .readyBusy_n(readyBusy_n));

  task automatic results();
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // entered just after a rising edge; leaves one idle edge so psel is never set twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    lastCyc = 0;
    do
    begin
      @(posedge mclk);
      lastCyc++;
    end
    while (pready !== 1'b1 && lastCyc < 2000);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (lastCyc >= 2000)
    begin
      error_cnt++;
      results();
    end
    else
      @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk("read", exp, r & m);
  endtask

  task automatic op(input nbt_kind_type k, input logic [7:0] b, input logic ext, input logic xe);
    apb(1'b1, OFF_CTRL, 32'(b) | (32'(k) << CTRL_KIND_LSB) | (32'h1 << CTRL_GO_BIT)
        | (32'(ext) << CTRL_EXT_BIT));
    chk("ctrl err", 32'(xe), 32'(e));
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(OFF_TLIM, 32'd400, 32'hffffffff);
    rd(OFF_ISTAT, 32'h0, 32'h7);
    rd(OFF_STATUS, 32'h400, 32'h700);
    apb(1'b1, OFF_IEN, 32'h7);
    op(KIND_CMD, 8'h30, 1'b0, 1'b1);
    rd(OFF_ISTAT, 32'h4, 32'h7);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFF_ICLR, 32'h7);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h0, 32'(irq));
    op(KIND_CMD, CMD_RESET, 1'b0, 1'b0);
    chk("reset wait", 32'h1, 32'(lastCyc >= 25));
    rd(OFF_ISTAT, 32'h1, 32'h7);
    apb(1'b1, OFF_ICLR, 32'h7);
    rd(OFF_STATUS, 32'h500, 32'h700);
    op(KIND_CMD, CMD_STATUS, 1'b0, 1'b0);
    op(KIND_RDATA, 8'h00, 1'b0, 1'b0);
    rd(OFF_DATA, 32'h60, 32'hff);
    op(KIND_CMD, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++)
      op(KIND_ADDR, 8'(i), 1'b0, 1'b0);
    op(KIND_CMD, 8'h30, 1'b0, 1'b0);
    op(KIND_RDATA, 8'h00, 1'b1, 1'b0);
    rd(OFF_DATA, 32'h3c, 32'hff);
    apb(1'b1, OFF_TLIM, 32'd20);
    op(KIND_CMD, 8'h60, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
      op(KIND_ADDR, 8'(i), 1'b0, 1'b0);
    op(KIND_CMD, 8'hd0, 1'b0, 1'b0);
    rd(OFF_ISTAT, 32'h2, 32'h2);
    // the die is still erasing: poll the ready pin before the next command
    for (int i = 0; i < 100 && r[10] !== 1'b1; i++)
      apb(1'b0, OFF_STATUS, 32'h0);
    chk("ready", 32'h1, 32'(r[10]));
    apb(1'b1, OFF_TLIM, 32'd400);
    op(KIND_CMD, 8'h80, 1'b0, 1'b0);
    op(KIND_ADDR, 8'h00, 1'b0, 1'b0);
    op(KIND_WDATA, 8'ha5, 1'b0, 1'b0);
    chk("wdata pin", 32'ha5, 32'(pins.dataOut));
    chk("ce released", 32'h1, 32'(pins.chipEnable_n));
    op(KIND_CMD, CMD_PROGRAM, 1'b0, 1'b0);
    op(KIND_CMD, CMD_PROGRAM, 1'b0, 1'b1);
    op(KIND_CMD, CMD_SETFEAT, 1'b0, 1'b0);
    op(KIND_CMD, CMD_STATUS, 1'b0, 1'b0);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    chk("host slips", 32'h0, 32'(nbt_die_model_i.lateCmds));
    results();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    results();
  end
endmodule

/* File: rtl/nbt_host.sv */
// host controller: software cycles over APB drive one nand die's async bus
// assumes the die pins are asynchronous; busy pin and data in are synchronised
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
module nbt_host
  import nbt_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_DEF
)(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output nbt_pins_type     pins,
  input  wire logic [7:0]  dataIn,
  input  wire logic        readyBusy_n,
  output logic             irq
);
  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_WB, ST_BUSY, ST_GAP} nbt_state_type;

  nbt_state_type state_reg, state_next;
  nbt_pins_type  pins_reg, pins_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic          pready_reg, pready_next;
  logic          pslverr_reg, pslverr_next;
  logic [1:0]    kind_reg, kind_next;
  logic          extRead_reg, extRead_next;
  logic          waitBusy_reg, waitBusy_next;
  logic          resetSeen_reg, resetSeen_next;
  logic          switching_reg, switching_next;
  logic          pageArmed_reg, pageArmed_next;
  logic [7:0]    rdByte_reg, rdByte_next;
  logic [31:0]   cnt_reg, cnt_next;
  logic [31:0]   tlim_reg, tlim_next;
  logic [2:0]    ist_reg, ist_next;
  logic [2:0]    ien_reg, ien_next;
  logic          irq_reg, irq_next;
  logic [1:0]    rbSync_reg;
  logic [7:0]    dq1_reg, dq2_reg;
  logic [2:0]    evt;

  function automatic logic isBusyCmd(input logic [7:0] c);
    return c != CMD_STATUS && c != CMD_STATUSX && c != CMD_COLREAD && c != CMD_COLWRITE;
  endfunction

  always_ff @(posedge mclk)
  begin
    rbSync_reg <= {rbSync_reg[0], readyBusy_n};
    dq1_reg    <= dataIn;
    dq2_reg    <= dq1_reg;
  end

  wire logic access = psel && penable && !pready_reg;
  wire logic rbReady = rbSync_reg[1];

  always_comb
  begin
    state_next = state_reg;
    pins_next = pins_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    kind_next = kind_reg;
    extRead_next = extRead_reg;
    waitBusy_next = waitBusy_reg;
    resetSeen_next = resetSeen_reg;
    switching_next = switching_reg;
    pageArmed_next = pageArmed_reg;
    rdByte_next = rdByte_reg;
    cnt_next = cnt_reg;
    tlim_next = tlim_reg;
    ien_next = ien_reg;
    evt = 3'h0;
    case (state_reg)
      ST_IDLE:
      begin
        if (access)
        begin
          pready_next = 1'b1;
          case (paddr)
            OFF_CTRL:
              if (pwrite && pwdata[CTRL_GO_BIT])
              begin
                kind_next = pwdata[CTRL_KIND_LSB +: 2];
                extRead_next = pwdata[CTRL_EXT_BIT];
                // not-yet-reset die refuses all but reset; an interface switch refuses 70h and 78h
                // a repeat program confirm with no fresh address would reprogram the same page;
                // one-time pages allow more partial programs, which software has to police
                if ((!resetSeen_reg
                     && !(pwdata[9:8] == KIND_CMD && pwdata[7:0] == CMD_RESET))
                    || (switching_reg && pwdata[9:8] == KIND_CMD
                        && (pwdata[7:0] == CMD_STATUS || pwdata[7:0] == CMD_STATUSX))
                    || (!pageArmed_reg && pwdata[9:8] == KIND_CMD
                        && pwdata[7:0] == CMD_PROGRAM))
                begin
                  pslverr_next = 1'b1;
                  evt[IRQ_BLOCK] = 1'b1;
                end
                else
                begin
                  pready_next = 1'b0;
                  waitBusy_next = pwdata[9:8] == KIND_CMD && isBusyCmd(pwdata[7:0]);
                  if (pwdata[9:8] == KIND_CMD && pwdata[7:0] == CMD_RESET)
                    resetSeen_next = 1'b1;
                  if (pwdata[9:8] == KIND_ADDR)
                    pageArmed_next = 1'b1;
                  else if (pwdata[9:8] == KIND_CMD && pwdata[7:0] == CMD_PROGRAM)
                    pageArmed_next = 1'b0;
                  switching_next = pwdata[9:8] == KIND_CMD
                                   && (pwdata[7:0] == CMD_SETFEAT || pwdata[7:0] == CMD_RESET);
                  pins_next.chipEnable_n = 1'b0;
                  pins_next.cmdLatch = pwdata[9:8] == KIND_CMD;
                  pins_next.addrLatch = pwdata[9:8] == KIND_ADDR;
                  pins_next.dataOut = pwdata[7:0];
                  pins_next.dataOe_n = pwdata[9:8] == KIND_RDATA;
                  if (pwdata[9:8] == KIND_RDATA)
                    pins_next.readStrobe_n = 1'b0;
                  else
                    pins_next.writeStrobe_n = 1'b0;
                  state_next = ST_LOW;
                end
              end
            OFF_STATUS:
              prdata_next = {22'h0, switching_reg, resetSeen_reg, rdByte_reg}
                            | {23'h0, 1'b0, 8'h0} | (rbReady ? 32'h0000_0400 : 32'h0);
            OFF_DATA:  prdata_next = {24'h0, rdByte_reg};
            OFF_ISTAT: prdata_next = {29'h0, ist_reg};
            OFF_IEN:
            begin
              prdata_next = {29'h0, ien_reg};
              if (pwrite)
                ien_next = pwdata[2:0];
            end
            OFF_ICLR:  prdata_next = 32'h0;
            OFF_TLIM:
            begin
              prdata_next = tlim_reg;
              if (pwrite)
                tlim_next = pwdata;
            end
            default:   pslverr_next = 1'b1;
          endcase
        end
      end
      ST_LOW:
      begin
        // one cycle low and one high gives 40 ns low and high phases, well past min widths
        pins_next.writeStrobe_n = 1'b1;
        pins_next.readStrobe_n = 1'b1;
        state_next = ST_HIGH;
      end
      ST_HIGH:
      begin
        pins_next.cmdLatch = 1'b0;
        pins_next.addrLatch = 1'b0;
        pins_next.dataOe_n = 1'b1;
        cnt_next = 32'h0;
        state_next = ST_WB;
      end
      ST_WB:
      begin
        // no activity until busy has surely fallen and been synchronised
        cnt_next = cnt_reg + 32'h1;
        // synced data: count 0 holds the strobe-low sample, count 1 the one held after the rise
        if (kind_reg == KIND_RDATA && cnt_reg == (extRead_reg ? 32'h1 : 32'h0))
          rdByte_next = dq2_reg;
        if (cnt_reg >= 32'(WB_CYC + CCS_CYC + 2))
        begin
          cnt_next = 32'h0;
          state_next = waitBusy_reg ? ST_BUSY : ST_GAP;
        end
      end
      ST_BUSY:
      begin
        cnt_next = cnt_reg + 32'h1;
        if (rbReady)
        begin
          switching_next = 1'b0;
          evt[IRQ_DONE] = 1'b1;
          state_next = ST_GAP;
        end
        else if (cnt_reg >= tlim_reg)
        begin
          evt[IRQ_TOUT] = 1'b1;
          state_next = ST_GAP;
        end
      end
      ST_GAP:
      begin
        pready_next = 1'b1;
        pins_next.chipEnable_n = 1'b1;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    // set beats clear
    ist_next = (ist_reg & ~((access && pwrite && paddr == OFF_ICLR && state_reg == ST_IDLE)
                           ? pwdata[2:0] : 3'h0)) | evt;
    irq_next = |(ist_next & ien_next);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      pins_reg <= '{cmdLatch: 1'b0, addrLatch: 1'b0, chipEnable_n: 1'b1, writeStrobe_n: 1'b1,
                    readStrobe_n: 1'b1, dataOut: 8'h00, dataOe_n: 1'b1};
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      kind_reg <= 2'h0;
      extRead_reg <= 1'b0;
      waitBusy_reg <= 1'b0;
      resetSeen_reg <= 1'b0;
      switching_reg <= 1'b0;
      pageArmed_reg <= 1'b0;
      rdByte_reg <= 8'h00;
      cnt_reg <= 32'h0;
      tlim_reg <= 32'(TIMEOUT_CYC);
      ist_reg <= 3'h0;
      ien_reg <= 3'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      kind_reg <= kind_next;
      extRead_reg <= extRead_next;
      waitBusy_reg <= waitBusy_next;
      resetSeen_reg <= resetSeen_next;
      switching_reg <= switching_next;
      pageArmed_reg <= pageArmed_next;
      rdByte_reg <= rdByte_next;
      cnt_reg <= cnt_next;
      tlim_reg <= tlim_next;
      ist_reg <= ist_next;
      ien_reg <= ien_next;
      irq_reg <= irq_next;
    end
  end

  assign pins = pins_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  a_wb_quiet: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_HIGH) |=> (pins_reg.writeStrobe_n && pins_reg.readStrobe_n)[*4])
    else $error("strobe moved inside the busy settle window");
  a_reset_first: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_LOW && !pins_reg.writeStrobe_n && pins_reg.cmdLatch)
    |-> resetSeen_reg)
    else $error("command issued before the first reset");
  a_no_status_switch: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_LOW && pins_reg.cmdLatch && $past(switching_reg)
     && $past(state_reg) == ST_IDLE)
    |-> !(pins_reg.dataOut == CMD_STATUS || pins_reg.dataOut == CMD_STATUSX))
    else $error("status read during interface switch");
  a_done_on_ready: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_BUSY && rbReady) |=> (state_reg == ST_GAP) ##1 pready_reg)
    else $error("ready not acknowledged in two cycles");
  a_timeout_irq: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_BUSY && !rbReady && cnt_reg >= tlim_reg) |=> ist_reg[IRQ_TOUT])
    else $error("timeout not flagged");
  a_ext_capture: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_WB && cnt_reg == 32'h1 && kind_reg == KIND_RDATA && extRead_reg)
    |=> rdByte_reg == $past(dq2_reg))
    else $error("extended capture took wrong sample");
  a_one_program: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_LOW && pins_reg.cmdLatch && pins_reg.dataOut == CMD_PROGRAM)
    |-> $past(pageArmed_reg))
    else $error("page programmed twice without a new address");
  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    ##1 irq_reg == |($past(ist_next) & $past(ien_next)))
    else $error("irq out of step with status");
  a_ce_released: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_GAP) |=> pins_reg.chipEnable_n && pready_reg)
    else $error("chip enable held after transfer");
endmodule

/* File: rtl/nbt_pkg.sv */
// constants and types for the nand busy-timing host controller
// assumes a 25 MHz mclk and an APB slave port on the software side
// Notes on behaviour
// - die drops ready within 100 ns; host issues nothing in that window
// - host programs an ordinary page once, one-time pages up to eight times; code allows one program per address, no one-time count
// - host sends no 70h or 78h during an interface switch
// - host waits 200 ns after a column change before data transfer
// - read cycles under 30 ns use extended output capture
// - first host command after power-on is reset, then wait for ready
package nbt_pkg;
  localparam int CLK_MHZ = 25;
  localparam int CLK_NS  = 40;

  localparam int STROBE_TO_BUSY_NS = 100;
  localparam int COLUMN_CHANGE_NS  = 200;
  localparam int EXT_READ_LIMIT_NS = 30;
  localparam int WB_CYC   = (STROBE_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CCS_CYC  = (COLUMN_CHANGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POR_RESET_US   = 1000;
  localparam int ERASE_MAX_US   = 10000;
  localparam int PROGRAM_MAX_US = 2200;
  localparam int READ_MAX_US    = 50;
  localparam int TIMEOUT_DEF_US = 2 * ERASE_MAX_US;
  localparam int TIMEOUT_DEF    = TIMEOUT_DEF_US * CLK_MHZ;
  localparam int PROGRAM_LIMIT_OTP = 8;

  localparam logic [7:0] CMD_RESET    = 8'hff;
  localparam logic [7:0] CMD_SETFEAT  = 8'hef;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam logic [7:0] CMD_STATUSX  = 8'h78;
  localparam logic [7:0] CMD_COLREAD  = 8'he0;
  localparam logic [7:0] CMD_COLWRITE = 8'h85;
  localparam logic [7:0] CMD_PROGRAM  = 8'h10;

  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_DATA   = 12'h008;
  localparam logic [11:0] OFF_ISTAT  = 12'h00c;
  localparam logic [11:0] OFF_IEN    = 12'h010;
  localparam logic [11:0] OFF_ICLR   = 12'h014;
  localparam logic [11:0] OFF_TLIM   = 12'h018;

  localparam int CTRL_KIND_LSB = 8;
  localparam int CTRL_GO_BIT   = 10;
  localparam int CTRL_EXT_BIT  = 11;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_TOUT  = 1;
  localparam int IRQ_BLOCK = 2;

  typedef enum logic [1:0] {KIND_CMD, KIND_ADDR, KIND_WDATA, KIND_RDATA} nbt_kind_type;

  typedef struct packed {
    logic       cmdLatch;
    logic       addrLatch;
    logic       chipEnable_n;
    logic       writeStrobe_n;
    logic       readStrobe_n;
    logic [7:0] dataOut;
    logic       dataOe_n;
  } nbt_pins_type;
endpackage
